//--- inc/cr_seg_pkg.sv
// Shared constants and types for the card reader segment arbiter
package cr_seg_pkg;
  localparam int unsigned NUM_MASTERS     = 3;
  localparam int unsigned SEG_ADDR_W      = 20;
  localparam int unsigned CPU_ADDR_W      = 32;
  localparam int unsigned DATA_W          = 32;
  localparam int unsigned LIMIT_W         = 8;
  // Processor window prefix on the upper twelve bits
  localparam logic [11:0] WINDOW_PREFIX   = 12'h200;
  localparam logic [31:0] WINDOW_LAST     = 32'h200fffff;
  // Limit entry offsets in control register space
  localparam logic [15:0] LIMIT_BASE_OFS  = 16'h0c40;
  localparam logic [15:0] MEDIA_LIMIT_OFS = 16'h0c40;
  localparam logic [15:0] USB_LIMIT_OFS   = 16'h0c41;
  localparam logic [15:0] CPU_LIMIT_OFS   = 16'h0c42;
  localparam logic [7:0]  LIMIT_RESET     = 8'h10;
  // Slave base addresses on the segment
  localparam logic [19:0] MEDIA_SLV_BASE  = 20'h0f400;
  localparam logic [19:0] USB_SLV_BASE    = 20'h0f000;
  localparam logic [19:0] CPU_SLV_BASE    = 20'h0ec00;
  localparam logic [19:0] SLV_SPAN_MASK   = 20'hffc00;
  // Minimum tenure and idle run length in cycles
  localparam logic [7:0]  MIN_TENURE      = 8'h04;
  localparam logic [1:0]  IDLE_RUN        = 2'h2;
  // Bus transfer type: idle is the low code
  localparam logic [1:0]  HTRANS_IDLE     = 2'h0;
  typedef enum logic [1:0] {SLV_MEDIA, SLV_USB, SLV_CPU, SLV_NONE} slave_sel_type;
endpackage

//--- inc/cr_seg_if.sv
// Interface joining the arbiter end to the master side end
`timescale 1ns/1ps
`default_nettype none
interface cr_seg_if;
  import cr_seg_pkg::*;
  logic [NUM_MASTERS-1:0] hbusreq;
  logic [NUM_MASTERS-1:0] hgrant;
  logic [1:0]             htrans;
  logic [SEG_ADDR_W-1:0]  haddr;
  logic                   cfg_wr;
  logic [15:0]            cfg_addr;
  logic [LIMIT_W-1:0]     cfg_wdata;
  logic [LIMIT_W-1:0]     cfg_rdata;
  modport arbiter (input hbusreq, htrans, cfg_wr, cfg_addr, cfg_wdata,
                   output hgrant, haddr, cfg_rdata);
  modport masters (output hbusreq, htrans, cfg_wr, cfg_addr, cfg_wdata,
                   input hgrant, haddr, cfg_rdata);
endinterface
`default_nettype wire

//--- hdl/cr_rr_pick.sv
// Round-robin selector: next requester after the current owner
`timescale 1ns/1ps
`default_nettype none
module cr_rr_pick
  import cr_seg_pkg::*;
(
  // Requests and pointer
  input  wire logic [NUM_MASTERS-1:0] i_req,
  input  wire logic [1:0]             i_last,
  // Result
  output logic                        o_found,
  output logic [1:0]                  o_pick
);
  // Scan from the entry after the last owner, wrapping once
  always_comb begin
    logic [2:0] idx;
    idx     = 3'h0;
    o_found = 1'b0;
    o_pick  = 2'h0;
    for (int k = NUM_MASTERS; k >= 1; k--) begin
      idx = 3'({1'b0, i_last} + 3'(k));
      if (idx >= 3'(NUM_MASTERS)) begin
        idx = idx - 3'(NUM_MASTERS);
      end
      if (i_req[idx[1:0]]) begin
        o_found = 1'b1;
        o_pick  = idx[1:0];
      end
    end
  end
endmodule
`default_nettype wire

//--- hdl/cr_seg_arbiter.sv
// Arbiter end of the card reader segment: grants, limits and window
//
// Overview of operation
// - Processor window ending 0x200fffff goes to segment
// - Only twenty address bits reach the segment
// - Processor prefixes 0x200 to slave addresses
// - Round-robin, all masters equal priority
// - Two idle cycles with waiter move grant
// - Tenure past limit with waiter moves grant
// - Tenure counts every cycle, idle or busy
// - Limit changes apply after an arbitration cycle
// - New owner keeps grant at least four cycles unless it drops its request
// - Limit field 7:0, resets to 0x10
// - Three limit entries at 0x0c40 to 0x0c42
// - Software tunes limits, eighteen and four suggested
// - Masters drop request with no data
// - Masters release bus when grant drops
// - Masters use 32-bit data at bus clock
// - Completion notifications go before new data
// - Owners move as much data as possible
// - Segment big-endian, bridge swaps for processor
// - Slaves at 0x0f400, 0x0f000 and 0x0ec00
`timescale 1ns/1ps
`default_nettype none
module cr_seg_arbiter
  import cr_seg_pkg::*;
(
  // Clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_resetn,
  // Segment side
  cr_seg_if.arbiter                  bus,
  // Processor window
  input  wire logic [CPU_ADDR_W-1:0] i_cpu_addr,
  input  wire logic                  i_cpu_valid,
  output logic                       o_cpu_hit,
  output logic [SEG_ADDR_W-1:0]      o_cpu_seg_addr,
  // Slave decode of the segment address
  output logic [1:0]                 o_slave_sel,
  // Status
  output logic                       o_owner_valid,
  output logic [1:0]                 o_owner
);
  // Free or owned; a grant is only ever held while owned
  typedef enum logic [1:0] {ST_FREE, ST_OWNED} arb_state_type;

  // Slave decode used by the window and the segment
  function automatic logic [1:0] slave_of(input logic [19:0] a);
    if ((a & SLV_SPAN_MASK) == MEDIA_SLV_BASE) begin
      return SLV_MEDIA;
    end else if ((a & SLV_SPAN_MASK) == USB_SLV_BASE) begin
      return SLV_USB;
    end else if ((a & SLV_SPAN_MASK) == CPU_SLV_BASE) begin
      return SLV_CPU;
    end
    return SLV_NONE;
  endfunction

  arb_state_type      state_q, state_d;
  logic [LIMIT_W-1:0] limit_q [NUM_MASTERS];
  logic [LIMIT_W-1:0] act_limit_q, act_limit_d;
  logic [LIMIT_W-1:0] tenure_q, tenure_d;
  logic [1:0]         idle_q, idle_d;
  logic [1:0]         owner_q, owner_d;
  logic [NUM_MASTERS-1:0] grant_q, grant_d;
  logic               hit_q;
  logic [SEG_ADDR_W-1:0] cpu_seg_q;
  logic [1:0]         sel_q;
  logic [SEG_ADDR_W-1:0] haddr_q;
  logic [LIMIT_W-1:0] rdata_q;
  logic               owner_valid_q;

  // Window decode
  wire logic win_hit = i_cpu_valid && (i_cpu_addr[31:20] == WINDOW_PREFIX)
                       && (i_cpu_addr <= WINDOW_LAST);

  // Arbitration terms
  wire logic [NUM_MASTERS-1:0] others = bus.hbusreq & ~grant_q;
  wire logic waiting  = |others;
  wire logic min_done = tenure_q >= MIN_TENURE;
  wire logic idle_now = bus.htrans == HTRANS_IDLE;
  wire logic idle_out = (idle_q == IDLE_RUN) && waiting;
  wire logic over_lim = (tenure_q >= act_limit_q) && waiting;
  wire logic released = !bus.hbusreq[owner_q];
  logic       rr_found;
  logic [1:0] rr_pick;

  // Scan starts after the owner, so priority rotates evenly
  cr_rr_pick u_pick (
    .i_req   (bus.hbusreq),
    .i_last  (owner_q),
    .o_found (rr_found),
    .o_pick  (rr_pick)
  );

  // Next-state logic
  always_comb begin
    state_d     = state_q;
    owner_d     = owner_q;
    grant_d     = grant_q;
    act_limit_d = act_limit_q;
    // Tenure saturates so a long lone owner never wraps to a short count
    tenure_d    = (tenure_q == 8'hff) ? tenure_q : tenure_q + 8'h01;
    idle_d      = idle_now ? ((idle_q == IDLE_RUN) ? idle_q : idle_q + 2'h1) : 2'h0;
    case (state_q)
      ST_FREE: begin
        // Limit latched at grant, so a rewrite waits for the next tenure
        if (rr_found) begin
          state_d     = ST_OWNED;
          owner_d     = rr_pick;
          grant_d     = 3'(1) << rr_pick;
          act_limit_d = limit_q[rr_pick];
          tenure_d    = 8'h01;
          idle_d      = 2'h0;
        end
      end
      ST_OWNED: begin
        // An owner dropping its request frees the bus at once, no minimum
        if (released || (min_done && (idle_out || over_lim))) begin
          grant_d = '0;
          if (rr_found && (rr_pick != owner_q || released)) begin
            owner_d     = rr_pick;
            grant_d     = 3'(1) << rr_pick;
            act_limit_d = limit_q[rr_pick];
            tenure_d    = 8'h01;
            idle_d      = 2'h0;
            if (rr_pick == owner_q) begin
              grant_d = '0;
              state_d = ST_FREE;
            end
          end else begin
            state_d = ST_FREE;
          end
        end
      end
      default: begin
        state_d = ST_FREE;
        grant_d = '0;
      end
    endcase
  end

  // Arbiter state
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      state_q     <= ST_FREE;
      owner_q     <= 2'(NUM_MASTERS - 1); // so entry 0 scans first
      grant_q     <= '0;
      act_limit_q <= LIMIT_RESET;
      tenure_q    <= 8'h00;
      idle_q      <= 2'h0;
      owner_valid_q <= 1'b0;
    end else begin
      state_q     <= state_d;
      owner_q     <= owner_d;
      grant_q     <= grant_d;
      act_limit_q <= act_limit_d;
      tenure_q    <= tenure_d;
      idle_q      <= idle_d;
      owner_valid_q <= (state_d == ST_OWNED);
    end
  end

  // Limit entries, one per master
  for (genvar m = 0; m < NUM_MASTERS; m++) begin : g_limit
    always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
        limit_q[m] <= LIMIT_RESET;
      end else if (bus.cfg_wr && bus.cfg_addr == LIMIT_BASE_OFS + 16'(m)) begin
        limit_q[m] <= bus.cfg_wdata;
      end
    end
  end

  // Limit readback; unmapped reads return zero
  wire logic [LIMIT_W-1:0] rd_mux =
    (bus.cfg_addr == MEDIA_LIMIT_OFS) ? limit_q[0] :
    (bus.cfg_addr == USB_LIMIT_OFS)   ? limit_q[1] :
    (bus.cfg_addr == CPU_LIMIT_OFS)   ? limit_q[2] : 8'h00;

  // Window and address outputs, registered
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      hit_q     <= 1'b0;
      cpu_seg_q <= '0;
      sel_q     <= SLV_NONE;
      haddr_q   <= '0;
      rdata_q   <= 8'h00;
    end else begin
      hit_q     <= win_hit;
      cpu_seg_q <= i_cpu_addr[SEG_ADDR_W-1:0]; // upper bits dropped
      sel_q     <= win_hit ? slave_of(i_cpu_addr[SEG_ADDR_W-1:0]) : SLV_NONE;
      haddr_q   <= i_cpu_addr[SEG_ADDR_W-1:0];
      rdata_q   <= rd_mux;
    end
  end

  // Every output comes straight from a register
  assign bus.hgrant    = grant_q;
  assign bus.haddr     = haddr_q;
  assign bus.cfg_rdata = rdata_q;
  assign o_cpu_hit      = hit_q;
  assign o_cpu_seg_addr = cpu_seg_q;
  assign o_slave_sel    = sel_q;
  assign o_owner_valid  = owner_valid_q;
  assign o_owner        = owner_q;
endmodule
`default_nettype wire

//--- hdl/cr_seg_masters.sv
// Master side end: three requesters and limit programming
`timescale 1ns/1ps
`default_nettype none
module cr_seg_masters
  import cr_seg_pkg::*;
(
  // Clock and reset
  input  wire logic                   i_clk,
  input  wire logic                   i_resetn,
  // Segment side
  cr_seg_if.masters                   bus,
  // User side: per-master pending work
  input  wire logic [NUM_MASTERS-1:0] i_has_data,
  input  wire logic [NUM_MASTERS-1:0] i_busy_cycle,
  // User side: limit programming
  input  wire logic                   i_cfg_wr,
  input  wire logic [15:0]            i_cfg_addr,
  input  wire logic [LIMIT_W-1:0]     i_cfg_wdata,
  output logic [LIMIT_W-1:0]          o_cfg_rdata,
  // User side: granted status
  output logic [NUM_MASTERS-1:0]      o_granted
);
  logic [NUM_MASTERS-1:0] req_q;
  logic [1:0]             htrans_q;
  logic                   wr_q;
  logic [15:0]            addr_q;
  logic [LIMIT_W-1:0]     wdata_q;
  logic [LIMIT_W-1:0]     rdata_q;
  logic [NUM_MASTERS-1:0] gnt_q;

  // Granted, requesting masters with a busy cycle; any set bit drives busy code 2
  wire logic [NUM_MASTERS-1:0] active = bus.hgrant & req_q & i_busy_cycle;

  // Request only with data, release on grant loss
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      req_q    <= '0;
      htrans_q <= HTRANS_IDLE;
      wr_q     <= 1'b0;
      addr_q   <= 16'h0000;
      wdata_q  <= 8'h00;
      rdata_q  <= 8'h00;
      gnt_q    <= '0;
    end else begin
      req_q    <= i_has_data;
      htrans_q <= (|active) ? 2'h2 : HTRANS_IDLE;
      wr_q     <= i_cfg_wr;
      addr_q   <= i_cfg_addr;
      wdata_q  <= i_cfg_wdata;
      rdata_q  <= bus.cfg_rdata;
      gnt_q    <= bus.hgrant & req_q;
    end
  end

  assign bus.hbusreq   = req_q;
  assign bus.htrans    = htrans_q;
  assign bus.cfg_wr    = wr_q;
  assign bus.cfg_addr  = addr_q;
  assign bus.cfg_wdata = wdata_q;
  assign o_cfg_rdata   = rdata_q;
  assign o_granted     = gnt_q;
endmodule
`default_nettype wire

//--- verif/cr_seg_asserts.sv
// Checker for grant, tenure and limit behaviour on the segment
`timescale 1ns/1ps
`default_nettype none
module cr_seg_asserts
  import cr_seg_pkg::*;
(
  // Clock and reset
  input wire logic                   i_clk,
  input wire logic                   i_resetn,
  // Segment signals, watched only
  input wire logic [NUM_MASTERS-1:0] i_hbusreq,
  input wire logic [NUM_MASTERS-1:0] i_hgrant,
  input wire logic [1:0]             i_htrans,
  input wire logic                   i_cfg_wr,
  input wire logic [15:0]            i_cfg_addr,
  input wire logic [LIMIT_W-1:0]     i_cfg_wdata,
  input wire logic [LIMIT_W-1:0]     i_cfg_rdata
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  logic [2:0] g_q;
  logic [7:0] ten_q;
  logic [7:0] lim_q [3];
  // Owner index, its limit floored at the minimum tenure, waiters, readback
  wire logic [1:0] own_w = g_q[1] ? 2'h1 : (g_q[2] ? 2'h2 : 2'h0);
  wire logic [7:0] cap_w = (lim_q[own_w] < MIN_TENURE) ? MIN_TENURE : lim_q[own_w];
  wire logic       wait_w = (i_hbusreq & ~g_q) != 3'h0;
  wire logic       ent_w  = (i_cfg_addr[15:2] == LIMIT_BASE_OFS[15:2])
                            && (i_cfg_addr[1:0] != 2'h3);
  wire logic [7:0] rd_w   = ent_w ? lim_q[i_cfg_addr[1:0]] : 8'h00;
  // Tenure saturates so a long lone owner never wraps to a short count
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      g_q <= 3'h0;
      ten_q <= 8'h00;
      lim_q <= '{LIMIT_RESET, LIMIT_RESET, LIMIT_RESET};
    end else begin
      g_q <= i_hgrant;
      ten_q <= (i_hgrant != g_q) ? 8'h01 : ((ten_q == 8'hff) ? ten_q : ten_q + 8'h01);
      if (i_cfg_wr && ent_w) lim_q[i_cfg_addr[1:0]] <= i_cfg_wdata;
    end
  end
  // Two idle beats with a waiter, and a quiet limit bus for readback
  sequence s_idle2;
    (g_q != 3'h0 && wait_w && i_htrans == HTRANS_IDLE && ten_q >= 8'h05)[*2];
  endsequence
  sequence s_rd_steady;
    (!i_cfg_wr && $stable(i_cfg_addr))[*3];
  endsequence
  // Grant properties; a move may take two cycles of pipeline slack
  property p_onehot; $onehot0(i_hgrant); endproperty
  property p_reset; $rose(i_resetn) |-> i_hgrant == 3'h0; endproperty
  property p_req;
    i_hgrant != 3'h0 && i_hgrant != $past(i_hgrant) |-> (i_hgrant & $past(i_hbusreq)) != 3'h0;
  endproperty
  property p_min;
    i_hgrant != g_q && (g_q & i_hbusreq & $past(i_hbusreq)) != 3'h0 |-> ten_q >= MIN_TENURE;
  endproperty
  property p_idle; s_idle2 |-> ##[0:2] i_hgrant != g_q; endproperty
  property p_limit; g_q != 3'h0 && wait_w && ten_q == cap_w |-> ##[0:2] i_hgrant != g_q;
  endproperty
  property p_alone;
    i_hgrant != 3'h0 && (i_hbusreq & i_hgrant) != 3'h0 && (i_hbusreq & ~i_hgrant) == 3'h0
    |=> i_hgrant == $past(i_hgrant);
  endproperty
  property p_cfg_read; s_rd_steady |-> i_cfg_rdata == rd_w; endproperty
  a_onehot: assert property (p_onehot) else $error("grant not one-hot");
  a_reset: assert property (p_reset) else $error("grant after reset");
  a_req: assert property (p_req) else $error("grant without request");
  a_min: assert property (p_min) else $error("tenure too short");
  a_idle: assert property (p_idle) else $error("idle owner kept bus");
  a_limit: assert property (p_limit) else $error("limit not applied");
  a_alone: assert property (p_alone) else $error("lone owner lost bus");
  a_cfg_read: assert property (p_cfg_read) else $error("limit readback wrong");
endmodule
`default_nettype wire

//--- verif/tb.sv
// Testbench joining both ends of the card reader segment
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin cmp_count++; if ((s) !== (e)) begin fail_count++; \
  $display("mismatch %s exp %h got %h", nm, e, s); end end
module tb;
  import cr_seg_pkg::*;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic [31:0] cpu_addr = 32'h0;
  logic        cpu_valid = 1'b0;
  logic [2:0]  has_data = 3'h0;
  logic [2:0]  busy_cycle = 3'h0;
  logic        cfg_wr = 1'b0;
  logic [15:0] cfg_addr = 16'h0;
  logic [7:0]  cfg_wdata = 8'h0;
  logic [7:0]  cfg_rdata;
  logic        cpu_hit;
  logic        owner_valid;
  logic [19:0] seg_addr;
  logic [1:0]  slave_sel;
  logic [1:0]  owner;
  logic [2:0]  granted;
  int          fail_count = 0;
  int          cmp_count = 0;
  int          cyc_count = 0;
  always #5 clk = ~clk;
  cr_seg_if bus ();
  cr_seg_arbiter i_cr_seg_arbiter (.i_clk(clk), .i_resetn(resetn), .bus(bus.arbiter),
    .i_cpu_addr(cpu_addr), .i_cpu_valid(cpu_valid), .o_cpu_hit(cpu_hit),
    .o_cpu_seg_addr(seg_addr), .o_slave_sel(slave_sel), .o_owner_valid(owner_valid),
    .o_owner(owner));
  cr_seg_masters i_cr_seg_masters (.i_clk(clk), .i_resetn(resetn), .bus(bus.masters),
    .i_has_data(has_data), .i_busy_cycle(busy_cycle), .i_cfg_wr(cfg_wr),
    .i_cfg_addr(cfg_addr), .i_cfg_wdata(cfg_wdata), .o_cfg_rdata(cfg_rdata),
    .o_granted(granted));
  cr_seg_asserts i_cr_seg_asserts (.i_clk(clk), .i_resetn(resetn), .i_hbusreq(bus.hbusreq),
    .i_hgrant(bus.hgrant), .i_htrans(bus.htrans), .i_cfg_wr(bus.cfg_wr),
    .i_cfg_addr(bus.cfg_addr), .i_cfg_wdata(bus.cfg_wdata), .i_cfg_rdata(bus.cfg_rdata));
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    cfg_wr <= 1'b1;
    cfg_addr <= a;
    cfg_wdata <= d;
    @(posedge clk);
    cfg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk);
    cfg_addr <= a;
    cyc(5);
    `CHK("limit", e, cfg_rdata)
  endtask
  // Bounded wait so a stuck arbiter shows as a mismatch, not a hang
  task automatic wait_owner(input logic [1:0] o);
    for (int k = 0; k < 60 && !(owner_valid === 1'b1 && owner === o); k++) @(posedge clk);
    `CHK("owner", o, owner)
  endtask
  task automatic t_reset;
    `CHK("grant", 3'h0, bus.hgrant)
    rd(MEDIA_LIMIT_OFS, LIMIT_RESET);
    rd(USB_LIMIT_OFS, LIMIT_RESET);
    rd(CPU_LIMIT_OFS, LIMIT_RESET);
    rd(16'h0c43, 8'h00);
  endtask
  // Window edges plus the three slave bases, prefixed as the processor does
  task automatic t_window;
    logic [31:0] a [6] = '{32'h1fffffff, 32'h2000f400, 32'h2000f000, 32'h2000ec00,
                           32'h200fffff, 32'h20100000};
    logic [1:0]  s [6] = '{2'h3, 2'h0, 2'h1, 2'h2, 2'h3, 2'h3};
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      cpu_addr <= a[i];
      cpu_valid <= 1'b1;
      cyc(3);
      `CHK("hit", (i > 0 && i < 5), cpu_hit)
      if (i > 0 && i < 5) begin
        `CHK("seg", a[i][19:0], seg_addr)
        `CHK("haddr", a[i][19:0], bus.haddr)
        `CHK("sel", s[i], slave_sel)
      end
    end
  endtask
  task automatic t_rr;
    int n;
    int lim;
    wr(MEDIA_LIMIT_OFS, 8'h12);
    wr(USB_LIMIT_OFS, 8'h12);
    wr(CPU_LIMIT_OFS, 8'h04);
    rd(USB_LIMIT_OFS, 8'h12);
    @(posedge clk);
    has_data <= 3'h7;
    busy_cycle <= 3'h7;
    for (int i = 0; i < 4; i++) begin
      lim = (i % 3 == 2) ? 4 : 18;
      wait_owner(2'(i % 3));
      for (n = 0; n < 300 && owner_valid === 1'b1 && owner === 2'(i % 3); n++) @(posedge clk);
      `CHK("tenure", 1'b1, (n > lim - 3 && n < lim + 2))
    end
    // Processor alone far past its limit of four keeps the bus
    has_data <= 3'h4;
    cyc(12);
    `CHK("alone", 2'h2, owner)
    has_data <= 3'h0;
    cyc(6);
    `CHK("released", 1'b0, owner_valid)
  endtask
  task automatic t_idle;
    wr(MEDIA_LIMIT_OFS, 8'hff);
    @(posedge clk);
    has_data <= 3'h1;
    busy_cycle <= 3'h0;
    wait_owner(2'h0);
    cyc(12);
    `CHK("alone", 2'h0, owner)
    has_data <= 3'h3;
    wait_owner(2'h1);
    cyc(2);
    `CHK("granted", 3'h2, granted)
    has_data <= 3'h0;
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Ceiling well above the fewer than two hundred cycles the scenarios need
  always @(posedge clk) begin
    cyc_count++;
    if (cyc_count == 5000) begin
      fail_count++;
      give_verdict;
    end
  end
  initial begin
    cyc(20);
    resetn <= 1'b1;
    cyc(2);
    t_reset;
    t_window;
    t_rr;
    t_idle;
    give_verdict;
  end
endmodule
`default_nettype wire
